// [scan_pkg.sv]
// Purpose: shared constants and types for the conversion scan sequencer
// Assumes: 8-bit converter, four- or twelve-input variant chosen by parameter
// Notes:   mux select codes name the positive/negative inputs handed to the analog core
package scan_pkg;

  localparam int RESULT_BITS = 8;
  localparam int CODE_BITS   = 4;
  localparam int INPUT_BITS  = 4;
  localparam int SCAN_BITS   = 2;
  localparam int REF_BITS    = 3;
  localparam int FIFO_WIDTH  = 12;
  localparam int FIFO_DEPTH  = 16;
  localparam int REPEAT_COUNT = 8;

  // scan mode encodings
  localparam logic [1:0] SCAN_UP_FROM_ZERO = 2'h0;
  localparam logic [1:0] SCAN_REPEAT       = 2'h1;
  localparam logic [1:0] SCAN_UP_FROM_MID  = 2'h2;
  localparam logic [1:0] SCAN_SINGLE       = 2'h3;

  // mid-scan start inputs for the two variants
  localparam logic [3:0] MID_START_SMALL = 4'h2;
  localparam logic [3:0] MID_START_LARGE = 4'h6;

  // shared pin index on each variant
  localparam logic [3:0] SHARED_PIN_SMALL = 4'h3;
  localparam logic [3:0] SHARED_PIN_LARGE = 4'hB;

  // ground selector, used on the negative side or on the positive side for the shared pin
  localparam logic [3:0] GROUND_SEL = 4'hF;

  // reference source decode
  localparam logic [1:0] REF_SUPPLY   = 2'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h2;

  localparam logic [3:0] RESET_CODE = 4'h0;
  localparam logic [1:0] RESET_SCAN = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_CONVERT = 3'b010,
    ST_WAIT    = 3'b100
  } seq_state_e;

endpackage : scan_pkg

// [result_fifo.sv]
// Purpose: result buffer between conversion sequencer and host read path
// Assumes: single clock, synchronous active-low reset
// Notes:   full blocks writes, empty blocks reads; simultaneous push/pop allowed
`timescale 1ns/10ps
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             enable,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // handshake decode
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  // storage writes
  always_ff @(posedge clock) begin
    if (enable && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clock) begin
    if (!resetn || (enable && flush)) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (enable) begin
      if (push) wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
      if (pop) rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
      count <= (AW+1)'(count + push - pop);
    end
  end
endmodule : result_fifo

// [result_formatter.sv]
// Purpose: turns raw offset-binary sample into host result code
// Assumes: analog core returns unsigned code with midscale at 8'h80 in bipolar
// Notes:   registered output so data leaves from flip-flops
`timescale 1ns/10ps
module result_formatter #(
  parameter int BITS = 8
) (
  input  wire logic            clock,
  input  wire logic            resetn,
  input  wire logic            enable,
  input  wire logic            load,
  input  wire logic            bipolar,
  input  wire logic            negate,
  input  wire logic [BITS-1:0] raw,
  output logic      [BITS-1:0] result
);
  logic [BITS-1:0] twos;
  logic [BITS-1:0] signed_val;
  logic [BITS-1:0] next_result;

  // two's complement is offset binary with msb flipped; negate for swapped pairs
  assign twos        = {~raw[BITS-1], raw[BITS-2:0]};
  assign signed_val  = negate ? BITS'(~twos + 1'b1) : twos;
  assign next_result = bipolar ? signed_val : raw;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      result <= '0;
    end else if (enable && load) begin
      result <= next_result;
    end
  end
endmodule : result_formatter

// [adc_scan_sequencer.sv]
// Purpose: conversion scan sequencing, input mux decode, reference decode
// Assumes: setup and configuration fields come from an upstream two-wire decoder
// Notes:   one conversion per start/done handshake with the analog core
`timescale 1ns/10ps
module adc_scan_sequencer
  import scan_pkg::*;
#(
  parameter bit TWELVE_INPUTS = 1'b1
) (
  input  wire logic                           clock,
  input  wire logic                           resetn,
  input  wire logic                           clock_enable,
  input  wire logic [scan_pkg::CODE_BITS-1:0] channel_select_code,
  input  wire logic [scan_pkg::SCAN_BITS-1:0] scan_mode,
  input  wire logic [scan_pkg::REF_BITS-1:0]  reference_select,
  input  wire logic                           single_ended_select,
  input  wire logic                           bipolar_select,
  input  wire logic                           external_clock_mode,
  input  wire logic                           start_scan,
  input  wire logic                           host_nack,
  output logic                                busy,
  output logic                                convert_start,
  output logic [scan_pkg::INPUT_BITS-1:0]     mux_positive,
  output logic [scan_pkg::INPUT_BITS-1:0]     mux_negative,
  input  wire logic                           convert_done,
  input  wire logic [scan_pkg::RESULT_BITS-1:0] convert_raw,
  output logic [1:0]                          reference_source,
  output logic                                shared_pin_is_input,
  output logic                                shared_pin_drives_reference,
  output logic                                internal_reference_on,
  output logic                                internal_reference_auto_off,
  output logic [scan_pkg::RESULT_BITS-1:0]    result_data,
  output logic [scan_pkg::CODE_BITS-1:0]      result_channel,
  output logic                                result_valid,
  input  wire logic                           result_ready
);

  seq_state_e state;
  seq_state_e next_state;

  logic [3:0] eff_code;
  logic [3:0] cur_code;
  logic [3:0] last_code;
  logic [3:0] mid_start;
  logic [3:0] shared_pin;
  logic [2:0] repeat_cnt;
  logic       pin_for_reference;
  logic       cur_single_ended;
  logic       cur_bipolar;
  logic       cur_continuous;
  logic [1:0] cur_scan;
  logic       stop_req;
  logic       pair_negate;
  logic       fmt_load;
  logic       push_pending;
  logic [3:0] push_code;
  logic [7:0] fmt_result;
  logic       fifo_in_ready;
  logic [11:0] fifo_out;
  logic        last_step;
  logic [3:0]  step_code;
  logic        repeating;

  // host-supplied select code, upper bits forced low on small variant
  assign eff_code = TWELVE_INPUTS ? channel_select_code
                                  : {2'h0, channel_select_code[1:0]};

  assign mid_start  = TWELVE_INPUTS ? MID_START_LARGE : MID_START_SMALL;
  assign shared_pin = TWELVE_INPUTS ? SHARED_PIN_LARGE : SHARED_PIN_SMALL;

  // reference decode: bit 1 steers pin use, bit 2 internal reference
  assign pin_for_reference           = reference_select[1];
  assign shared_pin_is_input         = ~reference_select[1];
  assign shared_pin_drives_reference = reference_select[2] & reference_select[1];
  assign internal_reference_on       = reference_select[2];
  assign internal_reference_auto_off = reference_select == 3'h4;
  assign reference_source = reference_select[2] ? REF_INTERNAL
                          : (reference_select[1] ? REF_EXTERNAL : REF_SUPPLY);

  // the scan start depends on mode; pair scans keep the code's parity, single inputs start at base in up scans, else at the code
  function automatic logic [3:0] scan_first(input logic [1:0] mode, input logic [3:0] code,
                                            input logic [3:0] mid, input logic se);
    logic [3:0] base;
    base = (mode == SCAN_UP_FROM_MID) ? mid : 4'h0;
    if (mode == SCAN_UP_FROM_ZERO || mode == SCAN_UP_FROM_MID) begin
      scan_first = se ? base : {base[3:1], code[0]};
    end else begin
      scan_first = code;
    end
  endfunction : scan_first

  // mid scan clamps the end at the start input when the selection is below it
  function automatic logic [3:0] scan_last(input logic [1:0] mode, input logic [3:0] code,
                                           input logic [3:0] mid);
    if (mode == SCAN_UP_FROM_MID && code < mid) begin
      scan_last = mid;
    end else begin
      scan_last = code;
    end
  endfunction : scan_last

  // pseudo-differential steps move a pair at a time, single-ended one input
  assign step_code = cur_single_ended ? 4'(cur_code + 4'h1) : 4'(cur_code + 4'h2);
  assign repeating = cur_scan == SCAN_REPEAT || cur_scan == SCAN_SINGLE;
  assign last_step = cur_continuous ? stop_req
                   : (cur_scan == SCAN_REPEAT) ? (repeat_cnt == 3'(REPEAT_COUNT - 1))
                   : (cur_scan == SCAN_SINGLE) ? 1'b1
                   : (cur_code >= last_code);

  // mux decode: pair partner is the other member; shared pin becomes ground while it serves the reference
  always_comb begin
    mux_positive = cur_code;
    mux_negative = GROUND_SEL;
    pair_negate  = 1'b0;
    if (!cur_single_ended) begin
      mux_negative = {cur_code[3:1], ~cur_code[0]};
      if (pin_for_reference && cur_code[3:1] == shared_pin[3:1]) begin
        // pin reads as ground, so the lower input sits on the far side
        mux_positive = {cur_code[3:1], 1'b0};
        mux_negative = GROUND_SEL;
        pair_negate  = cur_code[0];
      end
    end else if (pin_for_reference && cur_code == shared_pin) begin
      mux_positive = GROUND_SEL;
    end
  end

  // next-state logic; conversion waits for room in the buffer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:    if (start_scan) next_state = ST_CONVERT;
      ST_CONVERT: if (fifo_in_ready && !push_pending) next_state = ST_WAIT;
      ST_WAIT:    if (convert_done) next_state = last_step ? ST_IDLE : ST_CONVERT;
      default:    next_state = ST_IDLE;
    endcase
  end

  assign convert_start = state == ST_CONVERT && fifo_in_ready && !push_pending;
  assign busy          = state != ST_IDLE;
  assign fmt_load      = state == ST_WAIT && convert_done;

  // state register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  // scan pointer and settings latched at scan start so mid-scan writes do not tear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cur_code         <= RESET_CODE;
      last_code        <= RESET_CODE;
      cur_scan         <= RESET_SCAN;
      cur_single_ended <= 1'b1;
      cur_bipolar      <= 1'b0;
      cur_continuous   <= 1'b0;
      repeat_cnt       <= '0;
    end else if (clock_enable) begin
      if (state == ST_IDLE && start_scan) begin
        cur_code         <= scan_first(scan_mode, eff_code, mid_start, single_ended_select);
        last_code        <= scan_last(scan_mode, eff_code, mid_start);
        cur_scan         <= scan_mode;
        cur_single_ended <= single_ended_select;
        cur_bipolar      <= bipolar_select;
        cur_continuous   <= external_clock_mode && scan_mode[0];
        repeat_cnt       <= '0;
      end else if (fmt_load && !last_step) begin
        if (!repeating) cur_code <= step_code;
        repeat_cnt <= 3'(repeat_cnt + 3'h1);
      end
    end
  end

  // not-acknowledge from the host ends a continuous run after the current result
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stop_req <= 1'b0;
    end else if (clock_enable) begin
      if (host_nack) begin
        stop_req <= 1'b1;
      end else if (state == ST_IDLE) begin
        stop_req <= 1'b0;
      end
    end
  end

  // one-cycle gap while the formatted byte moves into the buffer
  always_ff @(posedge clock) begin
    if (!resetn) begin
      push_pending <= 1'b0;
      push_code    <= RESET_CODE;
    end else if (clock_enable) begin
      push_pending <= fmt_load;
      if (fmt_load) push_code <= cur_code;
    end
  end

  result_formatter #(
    .BITS (RESULT_BITS)
  ) u_format (
    .clock   (clock),
    .resetn  (resetn),
    .enable  (clock_enable),
    .load    (fmt_load),
    .bipolar (cur_bipolar),
    .negate  (pair_negate),
    .raw     (convert_raw),
    .result  (fmt_result)
  );

  // results queue in conversion order, one 12-bit entry (channel code and byte) per conversion
  result_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .enable    (clock_enable),
    .flush     (1'b0),
    .in_data   ({push_code, fmt_result}),
    .in_valid  (push_pending),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (result_valid),
    .out_ready (result_ready)
  );

  assign result_data    = fifo_out[7:0];
  assign result_channel = fifo_out[11:8];

endmodule : adc_scan_sequencer

// [seq_chk.sv]
// Purpose: port-level checks for the scan sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   reference decode is checked as level relations
`timescale 1ns/10ps
module seq_chk
  import scan_pkg::*;
(
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       clock_enable,
  input wire logic       start_scan,
  input wire logic       busy,
  input wire logic       convert_start,
  input wire logic       convert_done,
  input wire logic [3:0] mux_positive,
  input wire logic [3:0] mux_negative,
  input wire logic [3:0] channel_select_code,
  input wire logic [1:0] scan_mode,
  input wire logic [2:0] reference_select,
  input wire logic       single_ended_select,
  input wire logic       result_valid,
  input wire logic       result_ready,
  input wire logic [7:0] result_data,
  input wire logic [1:0] reference_source,
  input wire logic       shared_pin_is_input,
  input wire logic       shared_pin_drives_reference,
  input wire logic       internal_reference_on,
  input wire logic       internal_reference_auto_off
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // result shows as valid at the buffer output two cycles after the core answers
  sequence s_result;
    ##2 result_valid;
  endsequence
  start_take_a: assert property (start_scan && !busy && clock_enable |=> busy)
    else $error("start not taken");
  pulse_one_a: assert property (convert_start |=> !convert_start)
    else $error("convert start longer than one cycle");
  done_result_a: assert property (convert_done && clock_enable |-> s_result)
    else $error("result late after conversion");
  hold_result_a: assert property (result_valid && !result_ready && clock_enable
    |=> result_valid && $stable(result_data))
    else $error("unread result changed");
  ref_pin_a: assert property (convert_start && reference_select[1] |->
    mux_positive != SHARED_PIN_LARGE && mux_negative != SHARED_PIN_LARGE)
    else $error("shared pin converted while used as reference");
  pair_parity_a: assert property (convert_start && !single_ended_select && scan_mode == 2'h0
    && !reference_select[1] |-> mux_positive[0] == channel_select_code[0]
    && mux_negative == (mux_positive ^ 4'h1) && mux_positive <= channel_select_code)
    else $error("pair order wrong");
  ref_supply_a: assert property (reference_select[2:1] == 2'h0 |-> reference_source == REF_SUPPLY
    && shared_pin_is_input && !shared_pin_drives_reference && !internal_reference_on)
    else $error("supply reference decode wrong");
  ref_ext_a: assert property (reference_select[2:1] == 2'h1 |-> reference_source == REF_EXTERNAL
    && !shared_pin_is_input && !shared_pin_drives_reference && !internal_reference_on)
    else $error("external reference decode wrong");
  ref_int_a: assert property (reference_select[2] |-> reference_source == REF_INTERNAL
    && shared_pin_is_input == !reference_select[1] && shared_pin_drives_reference
    == reference_select[1] && internal_reference_auto_off == (reference_select == 3'h4))
    else $error("internal reference decode wrong");
endmodule : seq_chk
bind adc_scan_sequencer seq_chk seq_chk_i (.clock, .resetn, .clock_enable, .start_scan, .busy,
  .convert_start, .convert_done, .mux_positive, .mux_negative, .channel_select_code, .scan_mode,
  .reference_select, .single_ended_select, .result_valid, .result_ready, .result_data,
  .reference_source, .shared_pin_is_input, .shared_pin_drives_reference,
  .internal_reference_on, .internal_reference_auto_off);

// [core_model.sv]
// Purpose: analog core stand-in answering conversion requests
// Assumes: mux selects valid in the cycle of convert_start
// Notes:   raw code is {positive, negative} so the mux choice shows in results
`timescale 1ns/10ps
module core_model (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       convert_start,
  input  wire logic [3:0] mux_positive,
  input  wire logic [3:0] mux_negative,
  output logic            convert_done = 1'b0,
  output logic [7:0]      convert_raw = 8'h00
);
  logic [3:0] wait_cnt;
  logic [7:0] held;
  // 1 to 8 cycles per conversion; raw is noise outside done so stale data never matches
  always @(posedge clock) begin
    convert_done <= 1'b0;
    convert_raw  <= 8'($random);
    if (!resetn) begin
      wait_cnt <= 4'h0;
    end else if (convert_start) begin
      held     <= {mux_positive, mux_negative};
      wait_cnt <= 4'(1 + ($random & 7));
    end else if (wait_cnt == 4'h1) begin
      convert_done <= 1'b1;
      convert_raw  <= held;
      wait_cnt     <= 4'h0;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule : core_model

// [adc_scan_sequencer_tb.sv]
// Purpose: self-checking bench for the scan sequencer
// Assumes: twelve-input variant, core model on the mux side
// Notes:   expected results come from a queue built per scan
`timescale 1ns/10ps
module adc_scan_sequencer_tb;
  import scan_pkg::*;
  logic       clock = 1'b0, resetn = 1'b0, clock_enable = 1'b1, single_ended_select = 1'b1;
  logic       bipolar_select = 1'b0, external_clock_mode = 1'b0, start_scan = 1'b0;
  logic       host_nack = 1'b0, result_ready = 1'b0, busy, convert_start, convert_done;
  logic       result_valid, shared_pin_is_input, shared_pin_drives_reference;
  logic       internal_reference_on, internal_reference_auto_off;
  logic [3:0] channel_select_code = 4'h0, mux_positive, mux_negative, result_channel;
  logic [1:0] scan_mode = 2'h0, reference_source;
  logic [2:0] reference_select = 3'h0;
  logic [7:0] convert_raw, result_data;
  logic [11:0] exp_q[$];
  int         n_errors = 0, n_tests = 0, seed = 32'h7f1c, k, t, n;
  adc_scan_sequencer adc_scan_sequencer_i (.clock, .resetn, .clock_enable, .channel_select_code,
    .scan_mode, .reference_select, .single_ended_select, .bipolar_select, .external_clock_mode,
    .start_scan, .host_nack, .busy, .convert_start, .mux_positive, .mux_negative, .convert_done,
    .convert_raw, .reference_source, .shared_pin_is_input, .shared_pin_drives_reference,
    .internal_reference_on, .internal_reference_auto_off, .result_data, .result_channel,
    .result_valid, .result_ready);
  core_model core_model_i (.clock, .resetn, .convert_start, .mux_positive, .mux_negative,
    .convert_done, .convert_raw);
  always #4 clock = ~clock;
  task automatic results();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(string what, logic [7:0] e, logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  // ground replaces the reference pin; odd top pair comes out negated in bipolar
  function automatic logic [7:0] conv(int c, bit se, bit rp, bit bp);
    logic [3:0] p, m;
    logic [7:0] raw;
    p = 4'(c);
    m = se ? 4'hF : p ^ 4'h1;
    raw = (!se && rp && c >= 10) ? 8'hAF : (se && rp && c == 11) ? 8'hFF : {p, m};
    if (!bp) return raw;
    return (!se && rp && c == 11) ? -(raw ^ 8'h80) : raw ^ 8'h80;
  endfunction : conv
  task automatic go(int m, int c, bit se, bit rp, bit bp, bit ext);
    @(posedge clock);
    scan_mode <= 2'(m);
    channel_select_code <= 4'(c);
    single_ended_select <= se;
    reference_select <= rp ? 3'h6 : 3'h5;
    bipolar_select <= bp;
    external_clock_mode <= ext;
    start_scan <= 1'b1;
    // held over a second edge: the block is surely busy there, so it must ignore it
    repeat (2) @(posedge clock);
    start_scan <= 1'b0;
  endtask : go
  // one scan: plan, start, drain with random host stalls, then expect silence
  task automatic run(int m, int c, bit se, bit rp, bit bp);
    int i;
    logic [11:0] e;
    case (m)
      0: for (i = se ? 0 : c % 2; i <= c; i += se ? 1 : 2)
        exp_q.push_back({4'(i), conv(i, se, rp, bp)});
      1: repeat (8) exp_q.push_back({4'(c), conv(c, se, rp, bp)});
      2: for (i = 6; i <= (c > 6 ? c : 6); i++)
        exp_q.push_back({4'(i), conv(i, se, rp, bp)});
      default: exp_q.push_back({4'(c), conv(c, se, rp, bp)});
    endcase
    go(m, c, se, rp, bp, 1'b0);
    t = 0;
    while ((exp_q.size() > 0 || busy !== 1'b0) && t < 2000) begin
      @(posedge clock);
      t++;
      if (result_valid === 1'b1 && result_ready === 1'b1) begin
        if (exp_q.size() == 0) chk("extra result", 8'h00, 8'h01);
        else begin
          e = exp_q.pop_front();
          chk("result_data", e[7:0], result_data);
          chk("result_channel", {4'h0, e[11:8]}, {4'h0, result_channel});
        end
      end
      result_ready <= 1'($random(seed));
    end
    // host stops reading so any surplus result stays visible to the idle check
    result_ready <= 1'b0;
    if (t >= 2000) begin
      n_errors++;
      results();
    end
    repeat (4) @(posedge clock);
    chk("result_valid idle", 8'h00, {7'h0, result_valid});
  endtask : run
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    // every reference code, with the clock enable toggled while idle
    for (k = 0; k < 8; k++) begin
      @(posedge clock);
      reference_select <= 3'(k);
      clock_enable <= k[0];
    end
    @(posedge clock);
    clock_enable <= 1'b1;
    run(0, 10, 0, 0, 0);
    run(0, 11, 0, 0, 0);
    run(3, 11, 0, 1, 1);
    run(0, 10, 0, 1, 0);
    run(2, 3, 1, 0, 0);
    run(2, 11, 1, 0, 0);
    run(1, 4, 1, 0, 1);
    run(0, 11, 1, 1, 0);
    for (k = 0; k < 12; k++) begin
      n = $random(seed) & 3;
      t = ($random(seed) & 15) % 11;
      run(n, t, n == 2 ? 1'b1 : 1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    end
    // continuous run: host stalls until the buffer refuses, then drains and ends it
    result_ready <= 1'b0;
    go(3, 5, 1, 0, 0, 1);
    repeat (300) @(posedge clock);
    chk("fifo holds", 8'h01, {7'h0, result_valid});
    t = 0;
    while ((busy !== 1'b0 || result_valid !== 1'b0) && t < 3000) begin
      @(posedge clock);
      t++;
      if (result_valid === 1'b1 && result_ready === 1'b1) begin
        chk("continuous result", conv(5, 1, 0, 0), result_data);
        chk("continuous channel", 8'h05, {4'h0, result_channel});
      end
      result_ready <= 1'b1;
      host_nack <= (t == 60);
    end
    if (t >= 3000) n_errors++;
    results();
  end
endmodule : adc_scan_sequencer_tb
